// >>> bms_pkg.sv
// Shared constants for the battery measurement sequencer
package bms_pkg;

  // Clock and base sample timing
  localparam int unsigned CLK_PERIOD_NS     = 40;
  localparam int unsigned SAMPLE_PERIOD_NS  = 687000;
  localparam int unsigned SAMPLE_PERIOD_CYC = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

  // Sample slots within one temperature cycle of ten base periods
  localparam logic [3:0] SLOTS_PER_TEMP = 4'ha;
  localparam logic [3:0] TEMP_SLOT      = 4'h9;
  localparam logic [3:0] OFFSET_SLOT    = 4'h4;

  // Averaging windows as log2 of the sample count
  localparam int unsigned CUR_LOG_N  = 7;
  localparam int unsigned AVG_LOG_N  = 12;
  localparam int unsigned VOLT_LOG_N = 2;
  localparam int unsigned TEMP_LOG_N = 5;

  // Offset tracker smoothing shift
  localparam int unsigned OFFSET_SHIFT = 4;

  // Word addresses of the result block
  localparam logic [15:0] ADDR_VOLT     = 16'h6003;
  localparam logic [15:0] ADDR_CUR      = 16'h6004;
  localparam logic [15:0] ADDR_TEMP     = 16'h6005;
  localparam logic [15:0] ADDR_ACC_MAIN = 16'h6006;
  localparam logic [15:0] ADDR_ACC_MID  = 16'h6007;
  localparam logic [15:0] ADDR_ACC_LOW  = 16'h6008;
  localparam logic [15:0] ADDR_AVG_CUR  = 16'h6009;
  localparam logic [15:0] ADDR_CONFIG   = 16'h600a;

  // Configuration word fields
  localparam int unsigned CFG_BLANK_BIT  = 0;
  localparam int unsigned CFG_SCD_BIT    = 3;
  localparam int unsigned CFG_DISCHARGE_OC_SC_THRESHOLD_SEL_LSB   = 4;
  localparam int unsigned CFG_CHARGE_OC_THRESHOLD_SEL_LSB   = 6;
  localparam int unsigned CFG_BIAS_LSB   = 8;
  localparam logic [15:0] CFG_WRITE_MASK = 16'hfff9;
  localparam logic [15:0] CFG_RESET      = 16'h0000;
  localparam logic [15:0] RESULT_RESET   = 16'h0000;

  // Saturation limits
  localparam logic [15:0] POS_LIMIT = 16'h7fff;
  localparam logic [15:0] NEG_LIMIT = 16'h8000;
  localparam logic [15:0] VOLT_MAX  = 16'h03ff;

  // Accumulator scaling: one current LSB is 2^8 fraction LSBs, one bias step 2^7
  localparam int unsigned ACC_W       = 48;
  localparam int unsigned CUR_SHIFT   = 8;
  localparam int unsigned BIAS_SHIFT  = 7;
  localparam logic signed [17:0] BLANK_LSB = 18'sh00020;

  // Protector threshold decodes in mV and delay in us
  localparam logic [7:0]  CHG_OC_MV [4] = '{8'h10, 8'h20, 8'h30, 8'h40};
  localparam logic [7:0]  DSG_SC_MV [4] = '{8'h64, 8'h8c, 8'hb4, 8'hdc};
  localparam logic [11:0] SC_DELAY_SHORT_US = 12'h0fa;
  localparam logic [11:0] SC_DELAY_LONG_US  = 12'h7d0;

endpackage

// >>> bms_averager.sv
// Windowed sample averager with saturating 16-bit result
`timescale 1ns/1ps
module bms_averager #(
  parameter int unsigned SW    = 18,
  parameter int unsigned LOG_N = 7
) (
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 sample_valid_in,
  input  wire logic signed [SW-1:0] sample_in,
  output logic                      result_valid_out,
  output logic [15:0]               result_out
);
  localparam int unsigned SUM_W = SW + LOG_N;
  // Compare at 17 bits at least, so the 16-bit limits keep their sign in narrow sums
  localparam int unsigned CMP_W = (SUM_W > 17) ? SUM_W : 17;

  logic signed [SUM_W-1:0] sum_r;
  logic        [LOG_N-1:0] cnt_r;
  logic signed [SUM_W-1:0] sum_nxt;
  logic signed [SUM_W-1:0] mean;
  logic signed [CMP_W-1:0] mean_wide;
  logic                    last;
  logic                    over_pos;
  logic                    over_neg;
  logic [15:0]             sat;

  assign sum_nxt  = sum_r + SUM_W'(sample_in);
  assign last     = &cnt_r;
  assign mean      = sum_nxt >>> LOG_N;
  assign mean_wide = CMP_W'(mean);
  assign over_pos  = mean_wide > CMP_W'(signed'(bms_pkg::POS_LIMIT));
  assign over_neg  = mean_wide < CMP_W'(signed'(bms_pkg::NEG_LIMIT));
  // Clamp rather than wrap
  assign sat = over_pos ? bms_pkg::POS_LIMIT :
               over_neg ? bms_pkg::NEG_LIMIT : mean_wide[15:0];

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sum_r            <= '0;
      cnt_r            <= '0;
      result_valid_out <= 1'b0;
      result_out       <= bms_pkg::RESULT_RESET;
    end else begin
      result_valid_out <= sample_valid_in && last;
      if (sample_valid_in) begin
        cnt_r <= cnt_r + 1'b1;
        sum_r <= last ? '0 : sum_nxt;
        if (last) begin
          result_out <= sat;
        end
      end
    end
  end
endmodule // bms_averager

// >>> bms_sequencer.sv
// Measurement sequencer: sampling, averaging, coulomb accumulation, result words
`timescale 1ns/1ps
// Contract
// - One current sample every 687 us, fed to all three current paths.
// - Current word refreshed every 88 ms with mean of 128 samples.
// - Average-current word refreshed every 2.8 s with mean of 4096 samples.
// - Current results are signed; positive means charging.
// - Current results clamp at 7fff and 8000, never wrap.
// - Offset cancellation on the current path runs always, no enable.
// - Voltage word updated every 3.4 ms, two's complement, 4.88 mV LSB.
// - Overrange voltage reads as 03ff, the top 10-bit code.
// - Temperature sampled every ten base periods and averaged.
// - Temperature word updated every 220 ms, 0.125 degree LSB.
// - Samples summed into a 16-bit signed accumulator that clamps.
// - Thirty-two fraction bits readable at 6007 and 6008.
// - Writing the main accumulator word clears all fraction bits.
// - With blanking on, small positive samples below 62.5 uV are skipped.
// - Signed bias field added to the accumulator every current sample.
// - Config bits 7:6 pick charge overcurrent threshold 16 to 64 mV.
// - Config bits 5:4 pick discharge overcurrent and short-circuit thresholds.
// - Config bit 3 picks short-circuit delay 250 us or 2 ms.
// - Results live in consecutive words starting at 6003.
module bms_sequencer #(
  parameter int unsigned SAMPLE_PERIOD_CYC = bms_pkg::SAMPLE_PERIOD_CYC
) (
  // Clock and reset
  input  wire logic               MCLK_IN,
  input  wire logic               RST_IN,
  // Converter front end readings
  input  wire logic signed [16:0] CURRENT_SAMPLE_IN,
  input  wire logic signed [16:0] OFFSET_SAMPLE_IN,
  input  wire logic        [11:0] VOLTAGE_SAMPLE_IN,
  input  wire logic signed [15:0] TEMP_SAMPLE_IN,
  // Sampling strobes to the front end
  output logic                    SAMPLE_TICK_OUT,
  output logic                    TEMP_SLOT_OUT,
  // Data memory word port
  input  wire logic        [15:0] MEM_ADDR_IN,
  input  wire logic               MEM_WR_IN,
  input  wire logic        [15:0] MEM_WDATA_IN,
  output logic             [15:0] MEM_RDATA_OUT,
  output logic                    MEM_HIT_OUT,
  // Protector settings
  output logic             [1:0]  CHG_OC_SEL_OUT,
  output logic             [1:0]  DSG_OC_SC_SEL_OUT,
  output logic                    SHORT_DELAY_SEL_OUT,
  output logic             [7:0]  CHG_OC_MV_OUT,
  output logic             [7:0]  DSG_OC_MV_OUT,
  output logic             [7:0]  SC_MV_OUT,
  output logic             [11:0] SC_DELAY_US_OUT
);
  localparam int unsigned AW = bms_pkg::ACC_W;
  // Clamp bounds held two bits wider so the signed compare cannot wrap
  localparam logic signed [AW+1:0] ACC_MAX = {3'b000, {(AW-1){1'b1}}};
  localparam logic signed [AW+1:0] ACC_MIN = {3'b111, {(AW-1){1'b0}}};

  // Input synchronisers: front end is outside this clock domain
  logic signed [16:0] cur_s1_r;
  logic signed [16:0] cur_s2_r;
  logic signed [16:0] off_s1_r;
  logic signed [16:0] off_s2_r;
  logic        [11:0] volt_s1_r;
  logic        [11:0] volt_s2_r;
  logic signed [15:0] temp_s1_r;
  logic signed [15:0] temp_s2_r;

  always_ff @(posedge MCLK_IN) begin
    cur_s1_r  <= CURRENT_SAMPLE_IN;
    cur_s2_r  <= cur_s1_r;
    off_s1_r  <= OFFSET_SAMPLE_IN;
    off_s2_r  <= off_s1_r;
    volt_s1_r <= VOLTAGE_SAMPLE_IN;
    volt_s2_r <= volt_s1_r;
    temp_s1_r <= TEMP_SAMPLE_IN;
    temp_s2_r <= temp_s1_r;
  end

  // Base sample period divider
  logic [31:0] div_r;
  logic [3:0]  slot_r;
  logic        tick;
  logic        temp_tick;
  logic        volt_tick;
  logic        off_tick;

  assign tick      = div_r == 32'(SAMPLE_PERIOD_CYC - 1);
  assign temp_tick = tick && (slot_r == bms_pkg::TEMP_SLOT);
  assign off_tick  = tick && (slot_r == bms_pkg::OFFSET_SLOT);
  // Four voltage samples per five periods, so a post every 3.4 ms
  assign volt_tick = tick && (slot_r != bms_pkg::TEMP_SLOT) &&
                     (slot_r != bms_pkg::OFFSET_SLOT);

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      div_r           <= '0;
      slot_r          <= '0;
      SAMPLE_TICK_OUT <= 1'b0;
      TEMP_SLOT_OUT   <= 1'b0;
    end else begin
      div_r           <= tick ? '0 : div_r + 32'h1;
      SAMPLE_TICK_OUT <= tick;
      TEMP_SLOT_OUT   <= temp_tick;
      if (tick) begin
        slot_r <= (slot_r == bms_pkg::SLOTS_PER_TEMP - 4'h1) ? 4'h0 : slot_r + 4'h1;
      end
    end
  end

  // Offset tracker: smoothed zero-input reading, subtracted from every current sample
  logic signed [16:0] offset_r;
  logic signed [17:0] off_diff;
  logic signed [17:0] offset_nxt;
  logic signed [17:0] cur_corr;

  assign off_diff   = 18'(off_s2_r) - 18'(offset_r);
  assign offset_nxt = 18'(offset_r) + (off_diff >>> bms_pkg::OFFSET_SHIFT);
  assign cur_corr   = 18'(cur_s2_r) - 18'(offset_r);

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      offset_r <= '0;
    end else if (off_tick) begin
      offset_r <= offset_nxt[16:0];
    end
  end

  // Averagers; signed sample keeps charge positive
  logic        cur_valid;
  logic [15:0] cur_mean;
  logic        avg_valid;
  logic [15:0] avg_mean;
  logic        volt_valid;
  logic [15:0] volt_mean;
  logic        temp_valid;
  logic [15:0] temp_mean;

  bms_averager #(.SW(18), .LOG_N(bms_pkg::CUR_LOG_N)) u_cur_avg (
    .clk_in           (MCLK_IN),
    .rst_in           (RST_IN),
    .sample_valid_in  (tick),
    .sample_in        (cur_corr),
    .result_valid_out (cur_valid),
    .result_out       (cur_mean)
  );

  bms_averager #(.SW(18), .LOG_N(bms_pkg::AVG_LOG_N)) u_long_avg (
    .clk_in           (MCLK_IN),
    .rst_in           (RST_IN),
    .sample_valid_in  (tick),
    .sample_in        (cur_corr),
    .result_valid_out (avg_valid),
    .result_out       (avg_mean)
  );

  bms_averager #(.SW(13), .LOG_N(bms_pkg::VOLT_LOG_N)) u_volt_avg (
    .clk_in           (MCLK_IN),
    .rst_in           (RST_IN),
    .sample_valid_in  (volt_tick),
    .sample_in        ({1'b0, volt_s2_r}),
    .result_valid_out (volt_valid),
    .result_out       (volt_mean)
  );

  // 32 temperature samples, 220 ms per post
  bms_averager #(.SW(16), .LOG_N(bms_pkg::TEMP_LOG_N)) u_temp_avg (
    .clk_in           (MCLK_IN),
    .rst_in           (RST_IN),
    .sample_valid_in  (temp_tick),
    .sample_in        (temp_s2_r),
    .result_valid_out (temp_valid),
    .result_out       (temp_mean)
  );

  // Result words
  logic [15:0] volt_r;
  logic [15:0] cur_r;
  logic [15:0] temp_r;
  logic [15:0] avg_r;
  logic [15:0] volt_clamped;

  // Overrange voltage pinned at the top code
  assign volt_clamped = ($signed(volt_mean) > $signed(bms_pkg::VOLT_MAX)) ?
                        bms_pkg::VOLT_MAX : volt_mean;

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      volt_r <= bms_pkg::RESULT_RESET;
      cur_r  <= bms_pkg::RESULT_RESET;
      temp_r <= bms_pkg::RESULT_RESET;
      avg_r  <= bms_pkg::RESULT_RESET;
    end else begin
      if (volt_valid) begin
        volt_r <= volt_clamped;
      end
      if (cur_valid) begin
        cur_r <= cur_mean;
      end
      if (temp_valid) begin
        temp_r <= temp_mean;
      end
      if (avg_valid) begin
        avg_r <= avg_mean;
      end
    end
  end

  // Configuration word
  logic [15:0] cfg_r;
  logic        cfg_wr;
  logic        acc_wr;

  assign cfg_wr = MEM_WR_IN && (MEM_ADDR_IN == bms_pkg::ADDR_CONFIG);
  assign acc_wr = MEM_WR_IN && (MEM_ADDR_IN == bms_pkg::ADDR_ACC_MAIN);

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      cfg_r <= bms_pkg::CFG_RESET;
    end else if (cfg_wr) begin
      cfg_r <= MEM_WDATA_IN & bms_pkg::CFG_WRITE_MASK;
    end
  end

  // Coulomb accumulator: 16 main bits over 32 fraction bits
  logic signed [AW-1:0] acc_r;
  logic signed [AW+1:0] acc_sum;
  logic signed [AW+1:0] cur_term;
  logic signed [AW+1:0] bias_term;
  logic signed [AW-1:0] acc_nxt;
  logic signed [7:0]    bias;
  logic                 blank;

  assign bias = cfg_r[bms_pkg::CFG_BIAS_LSB +: 8];
  // Small positive samples skipped when blanking is on
  assign blank = cfg_r[bms_pkg::CFG_BLANK_BIT] && (cur_corr > 18'sh0) &&
                 (cur_corr < bms_pkg::BLANK_LSB);
  assign cur_term  = blank ? '0 : ((AW+2)'(cur_corr) <<< bms_pkg::CUR_SHIFT);
  assign bias_term = (AW+2)'(bias) <<< bms_pkg::BIAS_SHIFT;
  // Sum then clamp at both ends
  assign acc_sum   = (AW+2)'(acc_r) + cur_term + bias_term;
  assign acc_nxt   = (acc_sum > ACC_MAX) ? ACC_MAX[AW-1:0] :
                     (acc_sum < ACC_MIN) ? ACC_MIN[AW-1:0] : acc_sum[AW-1:0];

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      acc_r <= '0;
    end else if (acc_wr) begin
      // Main word write clears the fraction
      acc_r <= {MEM_WDATA_IN, 32'h0000_0000};
    end else if (tick) begin
      acc_r <= acc_nxt;
    end
  end

  // Read decode of the result block
  logic [15:0] rd_mux;
  logic        hit;

  // Fraction words follow the main word
  assign rd_mux = (MEM_ADDR_IN == bms_pkg::ADDR_VOLT)     ? volt_r :
                  (MEM_ADDR_IN == bms_pkg::ADDR_CUR)      ? cur_r :
                  (MEM_ADDR_IN == bms_pkg::ADDR_TEMP)     ? temp_r :
                  (MEM_ADDR_IN == bms_pkg::ADDR_ACC_MAIN) ? acc_r[47:32] :
                  (MEM_ADDR_IN == bms_pkg::ADDR_ACC_MID)  ? acc_r[31:16] :
                  (MEM_ADDR_IN == bms_pkg::ADDR_ACC_LOW)  ? acc_r[15:0] :
                  (MEM_ADDR_IN == bms_pkg::ADDR_AVG_CUR)  ? avg_r :
                  (MEM_ADDR_IN == bms_pkg::ADDR_CONFIG)   ? cfg_r : 16'h0000;
  assign hit = (MEM_ADDR_IN >= bms_pkg::ADDR_VOLT) && (MEM_ADDR_IN <= bms_pkg::ADDR_CONFIG);

  // Registered read: value is sampled whole in one edge
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      MEM_RDATA_OUT <= 16'h0000;
      MEM_HIT_OUT   <= 1'b0;
    end else begin
      MEM_RDATA_OUT <= rd_mux;
      MEM_HIT_OUT   <= hit;
    end
  end

  // Protector settings, registered
  logic [1:0] charge_oc_threshold_sel;
  logic [1:0] discharge_oc_sc_threshold_sel;
  logic       short_delay_sel;

  assign charge_oc_threshold_sel = cfg_r[bms_pkg::CFG_CHARGE_OC_THRESHOLD_SEL_LSB +: 2];
  assign discharge_oc_sc_threshold_sel = cfg_r[bms_pkg::CFG_DISCHARGE_OC_SC_THRESHOLD_SEL_LSB +: 2];
  assign short_delay_sel = cfg_r[bms_pkg::CFG_SCD_BIT];

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      CHG_OC_SEL_OUT      <= 2'h0;
      DSG_OC_SC_SEL_OUT   <= 2'h0;
      SHORT_DELAY_SEL_OUT <= 1'b0;
      CHG_OC_MV_OUT       <= 8'h00;
      DSG_OC_MV_OUT       <= 8'h00;
      SC_MV_OUT           <= 8'h00;
      SC_DELAY_US_OUT     <= 12'h000;
    end else begin
      CHG_OC_SEL_OUT      <= charge_oc_threshold_sel;
      DSG_OC_SC_SEL_OUT   <= discharge_oc_sc_threshold_sel;
      SHORT_DELAY_SEL_OUT <= short_delay_sel;
      CHG_OC_MV_OUT       <= bms_pkg::CHG_OC_MV[charge_oc_threshold_sel];
      DSG_OC_MV_OUT       <= bms_pkg::CHG_OC_MV[discharge_oc_sc_threshold_sel];
      SC_MV_OUT           <= bms_pkg::DSG_SC_MV[discharge_oc_sc_threshold_sel];
      SC_DELAY_US_OUT     <= short_delay_sel ? bms_pkg::SC_DELAY_LONG_US : bms_pkg::SC_DELAY_SHORT_US;
    end
  end
endmodule // bms_sequencer

// >>> bms_seq_props.sv
// Port-level checker for the measurement sequencer
`timescale 1ns/1ps
module bms_seq_chk #(
  parameter int unsigned SAMPLE_PERIOD_CYC = 8
) (
  // Clock, reset and readings
  input wire logic               MCLK_IN,
  input wire logic               RST_IN,
  input wire logic signed [16:0] CURRENT_SAMPLE_IN,
  input wire logic signed [16:0] OFFSET_SAMPLE_IN,
  input wire logic        [11:0] VOLTAGE_SAMPLE_IN,
  input wire logic signed [15:0] TEMP_SAMPLE_IN,
  // Strobes and memory port
  input wire logic               SAMPLE_TICK_OUT,
  input wire logic               TEMP_SLOT_OUT,
  input wire logic        [15:0] MEM_ADDR_IN,
  input wire logic               MEM_WR_IN,
  input wire logic        [15:0] MEM_WDATA_IN,
  input wire logic        [15:0] MEM_RDATA_OUT,
  input wire logic               MEM_HIT_OUT,
  // Protector settings
  input wire logic        [1:0]  CHG_OC_SEL_OUT,
  input wire logic        [1:0]  DSG_OC_SC_SEL_OUT,
  input wire logic               SHORT_DELAY_SEL_OUT,
  input wire logic        [7:0]  CHG_OC_MV_OUT,
  input wire logic        [7:0]  DSG_OC_MV_OUT,
  input wire logic        [7:0]  SC_MV_OUT,
  input wire logic        [11:0] SC_DELAY_US_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);
  // Spacing counters; the seen flags skip the first pulse after reset
  logic [31:0] cyc_r;
  logic [3:0]  tks_r;
  logic        seen_r;
  logic        tseen_r;
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN || SAMPLE_TICK_OUT) begin
      cyc_r <= 32'h0;
    end else begin
      cyc_r <= cyc_r + 32'h1;
    end
  end
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      seen_r  <= 1'b0;
      tseen_r <= 1'b0;
      tks_r   <= 4'h0;
    end else begin
      seen_r  <= seen_r | SAMPLE_TICK_OUT;
      tseen_r <= tseen_r | TEMP_SLOT_OUT;
      tks_r   <= TEMP_SLOT_OUT ? 4'h0 : tks_r + {3'h0, SAMPLE_TICK_OUT};
    end
  end
  property p_readback;
    !$past(RST_IN) && $past(MEM_WR_IN) && $past(MEM_ADDR_IN) == 16'h600a &&
      MEM_ADDR_IN == 16'h600a && !MEM_WR_IN
      |=> MEM_RDATA_OUT == ($past(MEM_WDATA_IN, 2) & 16'hfff9);
  endproperty
  property p_chg;
    MEM_WR_IN && MEM_ADDR_IN == 16'h600a |-> ##2
      (CHG_OC_SEL_OUT == $past(MEM_WDATA_IN[7:6], 2) &&
       CHG_OC_MV_OUT == bms_pkg::CHG_OC_MV[$past(MEM_WDATA_IN[7:6], 2)]);
  endproperty
  property p_dsg;
    MEM_WR_IN && MEM_ADDR_IN == 16'h600a |-> ##2
      (DSG_OC_SC_SEL_OUT == $past(MEM_WDATA_IN[5:4], 2) &&
       DSG_OC_MV_OUT == bms_pkg::CHG_OC_MV[$past(MEM_WDATA_IN[5:4], 2)] &&
       SC_MV_OUT == bms_pkg::DSG_SC_MV[$past(MEM_WDATA_IN[5:4], 2)]);
  endproperty
  property p_delay;
    MEM_WR_IN && MEM_ADDR_IN == 16'h600a |-> ##2
      (SHORT_DELAY_SEL_OUT == $past(MEM_WDATA_IN[3], 2) &&
       SC_DELAY_US_OUT == ($past(MEM_WDATA_IN[3], 2) ? 12'h7d0 : 12'h0fa));
  endproperty
  chk_tick_period: assert property (
    SAMPLE_TICK_OUT && seen_r |-> cyc_r == 32'(SAMPLE_PERIOD_CYC - 1))
    else $error("sample tick spacing wrong");
  chk_temp_on_tick: assert property (TEMP_SLOT_OUT |-> SAMPLE_TICK_OUT)
    else $error("temperature slot off a tick");
  chk_temp_spacing: assert property (TEMP_SLOT_OUT && tseen_r |-> tks_r == 4'h9)
    else $error("temperature slot spacing wrong");
  chk_hit_window: assert property (!$past(RST_IN) |->
    MEM_HIT_OUT == ($past(MEM_ADDR_IN) inside {[16'h6003:16'h600a]}))
    else $error("hit flag disagrees with address");
  chk_unmapped_zero: assert property (!MEM_HIT_OUT |-> MEM_RDATA_OUT == 16'h0000)
    else $error("unmapped read not zero");
  chk_cfg_readback: assert property (p_readback)
    else $error("config readback wrong");
  chk_chg_decode: assert property (p_chg)
    else $error("charge threshold decode wrong");
  chk_dsg_decode: assert property (p_dsg)
    else $error("discharge threshold decode wrong");
  chk_delay_decode: assert property (p_delay)
    else $error("short delay decode wrong");
  cover property (TEMP_SLOT_OUT);
  cover property (MEM_HIT_OUT && MEM_RDATA_OUT == 16'h7fff);
  cover property (MEM_WR_IN && MEM_ADDR_IN == 16'h6006);
endmodule // bms_seq_chk

bind bms_sequencer bms_seq_chk #(.SAMPLE_PERIOD_CYC(SAMPLE_PERIOD_CYC)) u_chk (
  .MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .CURRENT_SAMPLE_IN(CURRENT_SAMPLE_IN),
  .OFFSET_SAMPLE_IN(OFFSET_SAMPLE_IN), .VOLTAGE_SAMPLE_IN(VOLTAGE_SAMPLE_IN),
  .TEMP_SAMPLE_IN(TEMP_SAMPLE_IN), .SAMPLE_TICK_OUT(SAMPLE_TICK_OUT),
  .TEMP_SLOT_OUT(TEMP_SLOT_OUT), .MEM_ADDR_IN(MEM_ADDR_IN), .MEM_WR_IN(MEM_WR_IN),
  .MEM_WDATA_IN(MEM_WDATA_IN), .MEM_RDATA_OUT(MEM_RDATA_OUT), .MEM_HIT_OUT(MEM_HIT_OUT),
  .CHG_OC_SEL_OUT(CHG_OC_SEL_OUT), .DSG_OC_SC_SEL_OUT(DSG_OC_SC_SEL_OUT),
  .SHORT_DELAY_SEL_OUT(SHORT_DELAY_SEL_OUT), .CHG_OC_MV_OUT(CHG_OC_MV_OUT),
  .DSG_OC_MV_OUT(DSG_OC_MV_OUT), .SC_MV_OUT(SC_MV_OUT), .SC_DELAY_US_OUT(SC_DELAY_US_OUT));

// >>> tb_bms_sequencer.sv
// Self-checking bench for the measurement sequencer
`timescale 1ns/1ps
module tb_bms_sequencer;
  // Short sample period keeps the long averaging windows affordable
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic signed [16:0] cur = '0;
  logic signed [16:0] offs = '0;
  logic        [11:0] volt = '0;
  logic signed [15:0] temp = '0;
  logic        [15:0] addr = '0;
  logic               wr = 1'b0;
  logic        [15:0] wdata = '0;
  logic        [15:0] rdata, v;
  logic               hit, h, tick, tslot, sdl_sel;
  logic        [1:0]  chg_sel, dsg_sel;
  logic        [7:0]  chg_mv, dsg_mv, sc_mv;
  logic        [11:0] sc_dly;
  int                 err_count = 0;
  int                 tests_run = 0;
  // Config rows: write, readback, charge mV, discharge mV, short mV, delay us
  logic [15:0] cfg_tab [4][6] = '{'{16'h0000, 16'h0000, 16'h10, 16'h10, 16'h64, 16'h0fa},
    '{16'h005e, 16'h0058, 16'h20, 16'h20, 16'h8c, 16'h7d0},
    '{16'ha5a7, 16'ha5a1, 16'h30, 16'h30, 16'hb4, 16'h0fa},
    '{16'hffff, 16'hfff9, 16'h40, 16'h40, 16'hdc, 16'h7d0}};
  // Accumulator rows: config, main write, current, then main, middle, lower after 10 ticks
  logic [15:0] acc_tab [6][6] = '{'{16'h0100, 16'h1234, 16'h0, 16'h1234, 16'h0, 16'h0500},
    '{16'hff00, 16'h8000, 16'h0000, 16'h8000, 16'h0000, 16'h0000},
    '{16'h0001, 16'h0000, 16'h000a, 16'h0000, 16'h0000, 16'h0000},
    '{16'h0000, 16'h0000, 16'h000a, 16'h0000, 16'h0000, 16'h6400},
    '{16'h0001, 16'h0000, 16'h0028, 16'h0000, 16'h0001, 16'h9000},
    '{16'h0001, 16'h0000, 16'hfff6, 16'hffff, 16'hffff, 16'h9c00}};
  // Measurement rows: current, current word, voltage, voltage word
  logic [16:0] cur_tab [4][4] = '{'{17'h003e8, 17'h03e8, 17'h0123, 17'h0123},
    '{17'h0ffff, 17'h7fff, 17'h0fff, 17'h03ff},
    '{17'h10000, 17'h8000, 17'h03ff, 17'h03ff},
    '{17'h1fffb, 17'hfffb, 17'h0000, 17'h0000}};

  bms_sequencer #(.SAMPLE_PERIOD_CYC(8)) DUT (
    .MCLK_IN(clk), .RST_IN(rst), .CURRENT_SAMPLE_IN(cur), .OFFSET_SAMPLE_IN(offs),
    .VOLTAGE_SAMPLE_IN(volt), .TEMP_SAMPLE_IN(temp), .SAMPLE_TICK_OUT(tick),
    .TEMP_SLOT_OUT(tslot), .MEM_ADDR_IN(addr), .MEM_WR_IN(wr), .MEM_WDATA_IN(wdata),
    .MEM_RDATA_OUT(rdata), .MEM_HIT_OUT(hit), .CHG_OC_SEL_OUT(chg_sel),
    .DSG_OC_SC_SEL_OUT(dsg_sel), .SHORT_DELAY_SEL_OUT(sdl_sel), .CHG_OC_MV_OUT(chg_mv),
    .DSG_OC_MV_OUT(dsg_mv), .SC_MV_OUT(sc_mv), .SC_DELAY_US_OUT(sc_dly));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_word(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Whole-word reads only
  // Read data is registered, so it is taken one edge after the address
  task automatic rd_word(input logic [15:0] a);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    #1;
    v = rdata;
    h = hit;
  endtask

  task automatic wait_ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      while (tick !== 1'b1) begin
        @(posedge clk);
        #1;
      end
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    conclude();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      rd_word(16'h6002 + 16'(i));
      check("reset word", v, 16'h0000);
      check("hit", {15'h0, h}, {15'h0, (i > 0 && i < 9)});
    end
    check("reset delay", {4'h0, sc_dly}, 16'h00fa);
    wr_word(16'h6004, 16'hffff);
    rd_word(16'h6004);
    check("read only word", v, 16'h0000);
    foreach (cfg_tab[i]) begin
      wr_word(16'h600a, cfg_tab[i][0]);
      rd_word(16'h600a);
      check("config", v, cfg_tab[i][1]);
      check("chg mv", {8'h0, chg_mv}, cfg_tab[i][2]);
      check("dsg mv", {8'h0, dsg_mv}, cfg_tab[i][3]);
      check("sc mv", {8'h0, sc_mv}, cfg_tab[i][4]);
      check("sc delay", {4'h0, sc_dly}, cfg_tab[i][5]);
    end
    // Main word is written right after a tick so no accumulate races the write
    foreach (acc_tab[i]) begin
      wr_word(16'h600a, acc_tab[i][0]);
      cur <= {acc_tab[i][2][15], acc_tab[i][2]};
      wait_ticks(1);
      wr_word(16'h6006, acc_tab[i][1]);
      wait_ticks(10);
      rd_word(16'h6006);
      check("acc main", v, acc_tab[i][3]);
      rd_word(16'h6007);
      check("acc middle", v, acc_tab[i][4]);
      rd_word(16'h6008);
      check("acc lower", v, acc_tab[i][5]);
    end
    @(posedge clk);
    temp <= 16'shffec;
    foreach (cur_tab[i]) begin
      @(posedge clk);
      cur  <= cur_tab[i][0];
      volt <= cur_tab[i][2][11:0];
      repeat (2100) @(posedge clk);
      rd_word(16'h6004);
      check("current", v, cur_tab[i][1][15:0]);
      rd_word(16'h6003);
      check("voltage", v, cur_tab[i][3][15:0]);
    end
    rd_word(16'h6005);
    check("temperature", v, 16'hffec);
    repeat (63600) @(posedge clk);
    rd_word(16'h6009);
    check("avg current", v, 16'hfffb);
    @(posedge clk);
    offs <= 17'h1ffe0;
    repeat (4200) @(posedge clk);
    rd_word(16'h6004);
    check("offset removed", v, 16'h001b);
    wr_word(16'h600a, 16'h00ff);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd_word(16'h600a);
    check("config after reset", v, 16'h0000);
    conclude();
  end
endmodule // tb_bms_sequencer
